// >>> common/clock_control_defines.vh
`ifndef CLOCK_CONTROL_DEFINES_VH
`define CLOCK_CONTROL_DEFINES_VH
// ===========================================
// register byte addresses
`define ADDR_INTERNAL_OSC_MODE      16'hffa0
`define ADDR_CPU_CLOCK_MODE         16'hffa1
`define ADDR_FAST_OSC_CONTROL       16'hffa2
`define ADDR_STABILIZATION_STATUS   16'hffa3
`define ADDR_STABILIZATION_WAIT_SEL 16'hffa4
// ===========================================
// field positions
`define BIT_INTERNAL_OSC_HALT       0
`define BIT_CPU_CLOCK_SELECT        0
`define BIT_CPU_CLOCK_STATUS        1
`define BIT_FAST_OSC_HALT           7
// ===========================================
// reset values
`define RST_INTERNAL_OSC_MODE       8'h00
`define RST_CPU_CLOCK_MODE          8'h00
`define RST_FAST_OSC_CONTROL        8'h00
`define RST_STABILIZATION_STATUS    8'h00
`define RST_STAB_STATUS_BITS        5'h00
`define RST_WAIT_SEL                3'h5
// ===========================================
// timing counts
`define STAB_COUNT_WIDTH            17
`define CPU_START_DELAY_CYCLES      5'h11
`endif

// >>> hdl/clock_switch_sync.v
`timescale 1ns/1ps
// ===========================================
// three-flop sampler of an outside level; change counts when stages 2 and 3 agree
module clock_switch_sync (
	input  wire i_clock,
	input  wire i_resetn,
	input  wire i_level,
	output reg  o_level
);
	reg stage1;
	reg stage2;
	reg stage3;

	always @(posedge i_clock or negedge i_resetn) begin
		if (!i_resetn) begin
			stage1  <= 1'b0;
			stage2  <= 1'b0;
			stage3  <= 1'b0;
			o_level <= 1'b0;
		end else begin
			stage1 <= i_level;
			stage2 <= stage1;
			stage3 <= stage2;
			if (stage2 == stage3) begin
				o_level <= stage3;
			end
		end
	end
endmodule

// >>> hdl/cpu_clock_select_osc_control.v
`timescale 1ns/1ps
`include "clock_control_defines.vh"
// Notes on behaviour
// R1 - internal oscillator halt honoured only if option allows and CPU runs fast clock
// R2 - internal osc mode bit 0: 0 oscillates, 1 stops internal oscillator
// R3 - reset clears internal osc mode, cpu clock mode and fast osc control to 00h
// R4 - software checks status reads 1 before halting internal oscillator
// R5 - cpu clock mode bit 0 selects internal (0) or fast (1) clock
// R6 - cpu clock mode bit 1 is read-only status of clock really in use
// R7 - peripherals get divided internal clock while internal clock drives CPU
// R8 - fast osc control honoured only while CPU runs from internal clock
// R9 - fast osc control bit 7 halts fast oscillator; other bits read zero
// R10 - software checks status reads 0 before halting fast oscillator
// R11 - stabilization status cleared on reset release, stop entry, fast halt set
// R12 - status bits 4..0 set and stay as 2^11,13,14,15,16 fast periods pass
// R13 - with RC oscillator software may switch without reading status
// R14 - wait codes 1..5 select 2^11..2^16 periods; reset loads 05h
// R15 - selected stop-release wait applies only when fast clock drives CPU
// R16 - after stop release counter stops at the selected wait threshold; code freezes the status bits there, counter keeps counting except at the 2^16 mark
// R17 - software programs wait selection before stop when on fast clock
// R18 - software writes wait selection after status shows time elapsed
// R19 - wait count starts only once oscillation has restarted
// R20 - wait select takes byte writes only; others take bit and byte access
// R21 - reset selects internal clock; CPU clock held 17 internal cycles
// R22 - clock switch is glitch-free; status flips once new source drives CPU
// R23 - unused register bits read zero and ignore writes
module cpu_clock_select_osc_control (
	input  wire        i_clock,
	input  wire        i_resetn,
	input  wire [15:0] i_addr,
	input  wire        i_write,
	input  wire        i_read,
	input  wire        i_bit_access,
	input  wire [2:0]  i_bit_index,
	input  wire [7:0]  i_wdata,
	output reg  [7:0]  o_rdata,
	input  wire        i_option_soft_stop,
	input  wire        i_stop_enter,
	input  wire        i_stop_release,
	input  wire        i_internal_osc_tick,
	input  wire        i_fast_osc_tick,
	input  wire        i_fast_osc_running,
	output reg         o_internal_osc_halt,
	output reg         o_fast_osc_halt,
	output reg         o_cpu_clock_enable,
	output reg         o_cpu_on_fast_clock,
	output reg         o_peripheral_on_internal,
	output reg         o_stop_wait_active
);
	// ===========================================
	// state and registers
	localparam ST_IDLE = 2'd0;
	localparam ST_WAIT = 2'd1;
	localparam ST_STOP = 2'd2;

	reg                          internal_osc_halt;
	reg                          cpu_clock_select;
	reg                          cpu_clock_status;
	reg                          fast_osc_halt;
	reg [4:0]                    stab_status;
	reg [2:0]                    wait_sel;
	reg [`STAB_COUNT_WIDTH-1:0]  stab_count;
	reg [4:0]                    stab_limit;
	reg [1:0]                    stop_state;
	reg [4:0]                    start_delay;
	reg [1:0]                    switch_phase;
	wire                         int_tick;
	wire                         fast_tick;
	wire                         fast_running;
	reg                          int_tick_q;
	reg                          fast_tick_q;
	wire                         int_edge;
	wire                         fast_edge;

	// ===========================================
	// sampling of oscillator-side signals
	clock_switch_sync sync_int (
		.i_clock  (i_clock),
		.i_resetn (i_resetn),
		.i_level  (i_internal_osc_tick),
		.o_level  (int_tick)
	);
	clock_switch_sync sync_fast (
		.i_clock  (i_clock),
		.i_resetn (i_resetn),
		.i_level  (i_fast_osc_tick),
		.o_level  (fast_tick)
	);
	clock_switch_sync sync_run (
		.i_clock  (i_clock),
		.i_resetn (i_resetn),
		.i_level  (i_fast_osc_running),
		.o_level  (fast_running)
	);

	always @(posedge i_clock or negedge i_resetn) begin
		if (!i_resetn) begin
			int_tick_q  <= 1'b0;
			fast_tick_q <= 1'b0;
		end else begin
			int_tick_q  <= int_tick;
			fast_tick_q <= fast_tick;
		end
	end
	assign int_edge  = int_tick & ~int_tick_q;
	assign fast_edge = fast_tick & ~fast_tick_q;

	// ===========================================
	// helpers
	// merged write value: bit access touches one bit, byte access all
	function [7:0] merge_write;
		input [7:0] old_value;
		input [7:0] wdata;
		input       bit_access;
		input [2:0] bit_index;
		reg   [7:0] mask;
		begin
			mask = 8'h01 << bit_index;
			if (bit_access) begin
				merge_write = (old_value & ~mask) | (wdata & mask);
			end else begin
				merge_write = wdata;
			end
		end
	endfunction

	// mask of done thresholds for a select code; prohibited codes act as longest
	function [4:0] limit_mask;
		input [2:0] code;
		begin
			case (code)
				3'h1:    limit_mask = 5'h10;
				3'h2:    limit_mask = 5'h18;
				3'h3:    limit_mask = 5'h1c;
				3'h4:    limit_mask = 5'h1e;
				default: limit_mask = 5'h1f;
			endcase
		end
	endfunction

	wire wr_int   = i_write && (i_addr == `ADDR_INTERNAL_OSC_MODE);
	wire wr_mode  = i_write && (i_addr == `ADDR_CPU_CLOCK_MODE);
	wire wr_fast  = i_write && (i_addr == `ADDR_FAST_OSC_CONTROL);
	wire wr_wait  = i_write && (i_addr == `ADDR_STABILIZATION_WAIT_SEL) && !i_bit_access; // R20

	wire [7:0] int_img  = {7'h00, internal_osc_halt};
	wire [7:0] mode_img = {6'h00, cpu_clock_status, cpu_clock_select};
	wire [7:0] fast_img = {fast_osc_halt, 7'h00};
	wire [7:0] int_new  = merge_write(int_img, i_wdata, i_bit_access, i_bit_index);
	wire [7:0] mode_new = merge_write(mode_img, i_wdata, i_bit_access, i_bit_index);
	wire [7:0] fast_new = merge_write(fast_img, i_wdata, i_bit_access, i_bit_index);

	// ===========================================
	// control registers
	always @(posedge i_clock or negedge i_resetn) begin
		if (!i_resetn) begin
			internal_osc_halt <= 1'b0; // R3
			cpu_clock_select  <= 1'b0; // R21
			fast_osc_halt     <= 1'b0; // R3
			wait_sel          <= `RST_WAIT_SEL; // R14
		end else begin
			// R1 R2
			if (wr_int && i_option_soft_stop && cpu_clock_status) begin
				internal_osc_halt <= int_new[`BIT_INTERNAL_OSC_HALT];
			end else if (!cpu_clock_status || !i_option_soft_stop) begin
				internal_osc_halt <= 1'b0;
			end
			if (wr_mode) begin
				cpu_clock_select <= mode_new[`BIT_CPU_CLOCK_SELECT]; // R5 R6 R23
			end
			if (wr_fast && !cpu_clock_status) begin
				fast_osc_halt <= fast_new[`BIT_FAST_OSC_HALT]; // R8 R9
			end
			if (wr_wait) begin
				wait_sel <= i_wdata[2:0]; // R14 R20
			end
		end
	end

	// ===========================================
	// glitch-free switch: gate off, wait two internal ticks, swap, gate on
	// a switch to fast is held off while the fast oscillator is halted or stopped
	always @(posedge i_clock or negedge i_resetn) begin
		if (!i_resetn) begin
			cpu_clock_status   <= 1'b0;
			switch_phase       <= 2'd0;
			start_delay        <= 5'h00;
			o_cpu_clock_enable <= 1'b0;
		end else begin
			if (start_delay != `CPU_START_DELAY_CYCLES) begin
				if (int_edge) begin
					start_delay <= start_delay + 5'h01; // R21
				end
				o_cpu_clock_enable <= 1'b0;
			end else if (cpu_clock_select != cpu_clock_status &&
			             (!cpu_clock_select || (!fast_osc_halt && fast_running))) begin
				o_cpu_clock_enable <= 1'b0; // R22
				if (int_edge) begin
					if (switch_phase == 2'd1) begin
						cpu_clock_status <= cpu_clock_select; // R22
						switch_phase     <= 2'd0;
					end else begin
						switch_phase <= switch_phase + 2'd1;
					end
				end
			end else begin
				switch_phase       <= 2'd0;
				o_cpu_clock_enable <= (stop_state == ST_IDLE);
			end
		end
	end

	// ===========================================
	// stabilization counter
	always @(posedge i_clock or negedge i_resetn) begin
		if (!i_resetn) begin
			stab_count  <= {`STAB_COUNT_WIDTH{1'b0}};
			stab_status <= `RST_STAB_STATUS_BITS; // R11
			stab_limit  <= 5'h1f;
			stop_state  <= ST_IDLE;
		end else begin
			if (i_stop_enter || (wr_fast && !cpu_clock_status && fast_new[`BIT_FAST_OSC_HALT])) begin
				stab_count  <= {`STAB_COUNT_WIDTH{1'b0}}; // R11
				stab_status <= 5'h00;
				stop_state  <= i_stop_enter ? ST_STOP : stop_state;
			end else begin
				case (stop_state)
					ST_STOP: begin
						if (i_stop_release) begin
							stab_limit <= limit_mask(wait_sel); // R16
							stop_state <= cpu_clock_status ? ST_WAIT : ST_IDLE; // R15
						end
					end
					ST_WAIT: begin
						if (stab_status == stab_limit) begin
							stop_state <= ST_IDLE;
						end
					end
					default: begin
						stop_state <= ST_IDLE;
					end
				endcase
				// R19: counting runs only on real oscillator edges
				if (fast_edge && fast_running && !fast_osc_halt && stop_state != ST_STOP &&
				    (stab_status & ~stab_limit) == 5'h00 && !stab_status[0]) begin
					stab_count <= stab_count + {{(`STAB_COUNT_WIDTH-1){1'b0}}, 1'b1};
					// R12
					if (stab_count == 17'd2047) stab_status[4] <= 1'b1;
					if (stab_count == 17'd8191) stab_status[3] <= stab_limit[3];
					if (stab_count == 17'd16383) stab_status[2] <= stab_limit[2];
					if (stab_count == 17'd32767) stab_status[1] <= stab_limit[1];
					if (stab_count == 17'd65535) stab_status[0] <= stab_limit[0];
				end
				if (stab_status == stab_limit && stab_limit != 5'h1f) begin
					stab_limit <= stab_limit; // R16
				end
			end
		end
	end

	// ===========================================
	// outputs and read path
	always @(posedge i_clock or negedge i_resetn) begin
		if (!i_resetn) begin
			o_internal_osc_halt      <= 1'b0;
			o_fast_osc_halt          <= 1'b0;
			o_cpu_on_fast_clock      <= 1'b0;
			o_peripheral_on_internal <= 1'b1;
			o_stop_wait_active       <= 1'b0;
			o_rdata                  <= 8'h00;
		end else begin
			o_internal_osc_halt      <= internal_osc_halt;
			o_fast_osc_halt          <= fast_osc_halt || stop_state == ST_STOP;
			o_cpu_on_fast_clock      <= cpu_clock_status;
			o_peripheral_on_internal <= !cpu_clock_status; // R7
			o_stop_wait_active       <= stop_state == ST_WAIT; // R15
			if (i_read) begin
				case (i_addr)
					`ADDR_INTERNAL_OSC_MODE:      o_rdata <= int_img;
					`ADDR_CPU_CLOCK_MODE:         o_rdata <= mode_img;
					`ADDR_FAST_OSC_CONTROL:       o_rdata <= fast_img;
					`ADDR_STABILIZATION_STATUS:   o_rdata <= {3'h0, stab_status}; // R23
					`ADDR_STABILIZATION_WAIT_SEL: o_rdata <= {5'h00, wait_sel};
					default:                      o_rdata <= 8'h00;
				endcase
			end
		end
	end
endmodule

// >>> verif/osc_model.sv
`timescale 1ns/1ps
// ===========================================
// oscillator circuits seen from the block
module osc_model (
	input  wire i_fast_halt,
	input  wire i_internal_halt,
	output reg  o_fast_tick,
	output reg  o_fast_running,
	output reg  o_internal_tick
);
	initial begin
		o_fast_tick = 1'b0;
		o_internal_tick = 1'b0;
		o_fast_running = 1'b0;
		o_fast_running <= #500 1'b1;
	end
	// odd half-periods keep the ticks unrelated to the system clock
	always #31 if (!i_fast_halt) o_fast_tick = !o_fast_tick;
	always #43 if (!i_internal_halt) o_internal_tick = !o_internal_tick;
	// start-up delay after restart, the wait must not include it
	always @(i_fast_halt) begin
		if (i_fast_halt) o_fast_running = 1'b0;
		else o_fast_running <= #500 1'b1;
	end
endmodule

// >>> verif/clock_control_assertions.sv
`timescale 1ns/1ps
// ===========================================
// port checks
module clock_control_assertions (
	input logic        i_clock,
	input logic        i_resetn,
	input logic [15:0] i_addr,
	input logic        i_read,
	input logic        i_stop_enter,
	input logic        i_option_soft_stop,
	input logic [7:0]  o_rdata,
	input logic        o_internal_osc_halt,
	input logic        o_fast_osc_halt,
	input logic        o_cpu_clock_enable,
	input logic        o_cpu_on_fast_clock,
	input logic        o_peripheral_on_internal
);
	default clocking cb @(posedge i_clock); endclocking
	default disable iff (!i_resetn);
	AST_START_GATED: assert property ($rose(i_resetn) |-> !o_cpu_clock_enable && !o_cpu_on_fast_clock)
		else $error("cpu clock live at reset release");
	AST_INT_HALT_GUARD: assert property ($rose(o_internal_osc_halt) |-> i_option_soft_stop && o_cpu_on_fast_clock)
		else $error("internal oscillator halted when not allowed");
	AST_FAST_HALT_GUARD: assert property ($rose(o_fast_osc_halt) && o_cpu_on_fast_clock |->
		$past(i_stop_enter) || $past(i_stop_enter, 2))
		else $error("fast oscillator halted while cpu on it");
	AST_PERIPH_CLOCK: assert property (o_cpu_on_fast_clock && $stable(o_cpu_on_fast_clock) |-> !o_peripheral_on_internal)
		else $error("peripherals on internal clock while cpu on fast");
	AST_SWITCH_GATED: assert property ($changed(o_cpu_on_fast_clock) |-> !$past(o_cpu_clock_enable))
		else $error("cpu clock not gated across switch");
	AST_FAST_RUNS: assert property ($rose(o_cpu_on_fast_clock) |-> !o_fast_osc_halt)
		else $error("status says fast clock while it is halted");
	AST_STATUS_READ: assert property (i_read && i_addr == 16'hffa1 |=>
		o_rdata[1] == $past(o_cpu_on_fast_clock) && o_rdata[7:2] == 6'h00)
		else $error("clock mode read wrong");
	AST_UNMAPPED: assert property (i_read && (i_addr < 16'hffa0 || i_addr > 16'hffa4) |=> o_rdata == 8'h00)
		else $error("unmapped read not zero");
	AST_STAB_ORDER: assert property (i_read && i_addr == 16'hffa3 |=>
		o_rdata inside {8'h00, 8'h10, 8'h18, 8'h1c, 8'h1e, 8'h1f})
		else $error("stabilization status out of order");
	AST_WAIT_SEL_BITS: assert property (i_read && i_addr == 16'hffa4 |=> o_rdata[7:3] == 5'h00)
		else $error("wait select upper bits set");
	cover property ($rose(o_cpu_on_fast_clock));
	cover property ($rose(o_internal_osc_halt));
	cover property ($rose(o_fast_osc_halt));
endmodule
bind cpu_clock_select_osc_control clock_control_assertions clock_control_assertions_i (
	.i_clock(i_clock), .i_resetn(i_resetn), .i_addr(i_addr), .i_read(i_read), .i_stop_enter(i_stop_enter),
	.i_option_soft_stop(i_option_soft_stop), .o_rdata(o_rdata), .o_internal_osc_halt(o_internal_osc_halt),
	.o_fast_osc_halt(o_fast_osc_halt), .o_cpu_clock_enable(o_cpu_clock_enable),
	.o_cpu_on_fast_clock(o_cpu_on_fast_clock), .o_peripheral_on_internal(o_peripheral_on_internal));

// >>> verif/cpu_clock_select_osc_control_test.sv
`timescale 1ns/1ps
// ===========================================
// scenario bench
module cpu_clock_select_osc_control_test;
	reg         i_clock;
	reg         i_resetn;
	reg  [15:0] i_addr;
	reg         i_write;
	reg         i_read;
	reg         i_bit_access;
	reg  [2:0]  i_bit_index;
	reg  [7:0]  i_wdata;
	reg         i_option_soft_stop;
	reg         i_stop_enter;
	reg         i_stop_release;
	wire        stop_wait;
	wire [7:0]  o_rdata;
	wire        int_tick, fast_tick, fast_running, int_halt, fast_halt, cpu_en, on_fast, periph_int;
	reg  [7:0]  rd_value;
	integer     failures;
	integer     checks_done;
	integer     c;

	cpu_clock_select_osc_control cpu_clock_select_osc_control_i (.i_clock(i_clock), .i_resetn(i_resetn),
		.i_addr(i_addr), .i_write(i_write), .i_read(i_read), .i_bit_access(i_bit_access),
		.i_bit_index(i_bit_index), .i_wdata(i_wdata), .o_rdata(o_rdata), .i_option_soft_stop(i_option_soft_stop),
		.i_stop_enter(i_stop_enter), .i_stop_release(i_stop_release), .i_internal_osc_tick(int_tick),
		.i_fast_osc_tick(fast_tick),
		.i_fast_osc_running(fast_running), .o_internal_osc_halt(int_halt), .o_fast_osc_halt(fast_halt),
		.o_cpu_clock_enable(cpu_en), .o_cpu_on_fast_clock(on_fast), .o_peripheral_on_internal(periph_int),
		.o_stop_wait_active(stop_wait));
	osc_model osc_model_i (.i_fast_halt(fast_halt), .i_internal_halt(int_halt), .o_fast_tick(fast_tick),
		.o_fast_running(fast_running), .o_internal_tick(int_tick));

	task stop_test;
		begin
			if (failures == 0 && checks_done > 0) begin
				$display("TB: PASS");
			end else begin
				$display("TB: FAIL");
			end
			$finish;
		end
	endtask
	task idle(input integer n);
		begin
			repeat (n) @(posedge i_clock);
			#1;
		end
	endtask
	task chk(input [7:0] got, input [7:0] exp);
		begin
			checks_done = checks_done + 1;
			if (got !== exp) begin
				failures = failures + 1;
				$display("ERROR t=%0t got %h exp %h", $time, got, exp);
			end
		end
	endtask
	task wr(input [15:0] a, input [7:0] d, input b, input [2:0] idx);
		begin
			i_addr = a;
			i_wdata = d;
			i_bit_access = b;
			i_bit_index = idx;
			i_write = 1'b1;
			idle(1);
			i_write = 1'b0;
			idle(1);
		end
	endtask
	task rd(input [15:0] a);
		begin
			i_addr = a;
			i_read = 1'b1;
			idle(1);
			i_read = 1'b0;
			rd_value = o_rdata;
			idle(1);
		end
	endtask
	task exp_rd(input [15:0] a, input [7:0] e);
		begin
			rd(a);
			chk(rd_value, e);
		end
	endtask
	// polls keep gaps so status can move between reads
	task poll(input [15:0] a, input [7:0] e, input integer n);
		integer k;
		begin
			rd_value = ~e;
			for (k = 0; k < n && rd_value !== e; k = k + 1) begin
				idle(20);
				rd(a);
			end
			chk(rd_value, e);
		end
	endtask
	task reset_dut;
		begin
			i_resetn = 1'b0;
			idle(5);
			i_resetn = 1'b1;
		end
	endtask
	task t_reset_state;
		begin
			idle(3);
			chk({7'h00, cpu_en}, 8'h00);
			exp_rd(16'hffa0, 8'h00);
			exp_rd(16'hffa1, 8'h00);
			exp_rd(16'hffa2, 8'h00);
			exp_rd(16'hffa3, 8'h00);
			exp_rd(16'hffa4, 8'h05);
			exp_rd(16'hffa7, 8'h00);
			for (c = 0; c < 400 && cpu_en !== 1'b1; c = c + 1) idle(1);
			chk({7'h00, cpu_en}, 8'h01);
			wr(16'hffa0, 8'h01, 1'b0, 3'h0);
			exp_rd(16'hffa0, 8'h00);
		end
	endtask
	task t_wait_select;
		begin
			wr(16'hffa4, 8'h00, 1'b1, 3'h2);
			exp_rd(16'hffa4, 8'h05);
			for (c = 1; c < 6; c = c + 1) begin
				wr(16'hffa4, c[7:0], 1'b0, 3'h0);
				exp_rd(16'hffa4, c[7:0]);
			end
			wr(16'hffa4, 8'hf9, 1'b0, 3'h0);
			exp_rd(16'hffa4, 8'h01);
		end
	endtask
	// first mark at 2^11 ticks of 62 ns, about 12700 cycles
	task t_stab_count;
		begin
			idle(9800);
			exp_rd(16'hffa3, 8'h00);
			poll(16'hffa3, 8'h10, 400);
		end
	endtask
	task t_switch_fast;
		begin
			wr(16'hffa1, 8'h01, 1'b0, 3'h0);
			poll(16'hffa1, 8'h03, 20);
			chk({6'h00, periph_int, on_fast}, 8'h01);
			wr(16'hffa2, 8'h80, 1'b0, 3'h0);
			exp_rd(16'hffa2, 8'h00);
			i_option_soft_stop = 1'b1;
			wr(16'hffa0, 8'h01, 1'b1, 3'h0);
			exp_rd(16'hffa0, 8'h01);
			chk({7'h00, int_halt}, 8'h01);
			wr(16'hffa0, 8'h00, 1'b0, 3'h0);
		end
	endtask
	task t_switch_back;
		begin
			wr(16'hffa1, 8'h00, 1'b0, 3'h0);
			poll(16'hffa1, 8'h00, 20);
			chk({7'h00, periph_int}, 8'h01);
			wr(16'hffa2, 8'h80, 1'b1, 3'h7);
			exp_rd(16'hffa2, 8'h80);
			chk({7'h00, fast_halt}, 8'h01);
			exp_rd(16'hffa3, 8'h00);
			wr(16'hffa2, 8'h00, 1'b0, 3'h0);
		end
	endtask
	// stop on the internal clock: no wait phase, status counts only to the selected mark
	task t_stop;
		begin
			wr(16'hffa4, 8'h01, 1'b0, 3'h0);
			i_stop_enter = 1'b1;
			idle(1);
			i_stop_enter = 1'b0;
			idle(2);
			chk({7'h00, fast_halt}, 8'h01);
			exp_rd(16'hffa3, 8'h00);
			i_stop_release = 1'b1;
			idle(1);
			i_stop_release = 1'b0;
			idle(2);
			chk({6'h00, stop_wait, fast_halt}, 8'h00);
			exp_rd(16'hffa3, 8'h00);
			poll(16'hffa3, 8'h10, 700);
			idle(3000);
			exp_rd(16'hffa3, 8'h10);
		end
	endtask

	initial begin
		i_clock = 1'b0;
		forever #5 i_clock = ~i_clock;
	end
	initial begin
		#1000000;
		failures = failures + 1;
		stop_test;
	end
	initial begin
		failures = 0;
		checks_done = 0;
		i_resetn = 1'b0;
		i_addr = 16'h0000;
		i_write = 1'b0;
		i_read = 1'b0;
		i_bit_access = 1'b0;
		i_bit_index = 3'h0;
		i_wdata = 8'h00;
		i_option_soft_stop = 1'b0;
		i_stop_enter = 1'b0;
		i_stop_release = 1'b0;
		reset_dut;
		t_reset_state;
		t_wait_select;
		t_stab_count;
		t_switch_fast;
		t_switch_back;
		t_stop;
		reset_dut;
		exp_rd(16'hffa4, 8'h05);
		stop_test;
	end
endmodule
